// ===== aofc_pkg.sv
// Constants and register layout for the output frame control block
package aofc_pkg;

  // Register bus
  localparam int          AOFC_ADDR_W      = 8;
  localparam logic [7:0]  AOFC_CTL_ADDR    = 8'h10;
  localparam logic [7:0]  AOFC_STAT_ADDR   = 8'h40;

  // Control register field positions
  localparam int          AOFC_TAG_BIT     = 14;
  localparam int          AOFC_SUP_LSB     = 12;
  localparam int          AOFC_INP_LSB     = 10;
  localparam int          AOFC_RNG_BIT     = 8;
  localparam int          AOFC_PAR_BIT     = 3;
  localparam int          AOFC_VAL_LSB     = 0;

  // Reset values of the writable fields
  localparam logic        AOFC_TAG_RST     = 1'b0;
  localparam logic [1:0]  AOFC_SUP_RST     = 2'h0;
  localparam logic [1:0]  AOFC_INP_RST     = 2'h0;
  localparam logic        AOFC_RNG_RST     = 1'b0;
  localparam logic        AOFC_PAR_RST     = 1'b0;
  localparam logic [2:0]  AOFC_VAL_RST     = 3'h0;

  // Status register field positions
  localparam int          AOFC_ST_STAGE    = 0;
  localparam int          AOFC_ST_BUSY     = 1;
  localparam int          AOFC_ST_LVL_LSB  = 4;

  // Frame geometry
  localparam int          AOFC_DATA_W      = 16;
  localparam int          AOFC_FRAME_MAX   = 30;
  localparam int          AOFC_LEN_W       = 5;
  localparam int          AOFC_FIFO_DEPTH  = 8;

  // Output value selections
  localparam logic [2:0]  AOFC_VAL_ZERO    = 3'h4;
  localparam logic [2:0]  AOFC_VAL_ONE     = 3'h5;
  localparam logic [2:0]  AOFC_VAL_ALT     = 3'h6;
  localparam logic [15:0] AOFC_PAT_ZERO    = 16'h0000;
  localparam logic [15:0] AOFC_PAT_ONE     = 16'hFFFF;
  localparam logic [15:0] AOFC_PAT_ALT     = 16'h5555;
  localparam logic [15:0] AOFC_PAT_PAIR    = 16'h3333;

endpackage : aofc_pkg

// ===== aofc_fifo.sv
// Frame FIFO with valid and ready on both sides
`timescale 1ns/1ps
module aofc_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } aofc_fifo_st_t;

  aofc_fifo_st_t st_q;
  aofc_fifo_st_t st_d;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  assign in_ready  = (st_q.count != CW'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = st_q.mem[st_q.rd_ptr];
  assign level     = st_q.count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = in_data;
      st_d.wr_ptr           = bump(st_q.wr_ptr);
    end
    if (pop) begin
      st_d.rd_ptr = bump(st_q.rd_ptr);
    end
    if (push && !pop) begin
      st_d.count = CW'(st_q.count + 1'b1);
    end else if (pop && !push) begin
      st_d.count = CW'(st_q.count - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : aofc_fifo

// ===== aofc_output_frame_control.sv
// Output frame builder, control register and serial sender
//
// Notes on behaviour
// R01 - Control bit 14 set appends the 4-bit device tag to every frame.
// R02 - Bits 13-12 pick supply alarm flags appended: none, high, low, or both.
// R03 - Bits 11-10 pick input alarm flags appended: none, high, low, or both.
// R04 - Control bit 8 set appends the current 4-bit input range code.
// R05 - Control bit 3 set appends two parity bits at the frame's end.
// R06 - First parity bit makes even parity over the data word alone.
// R07 - Second parity bit makes even parity over whole frame except first parity.
// R08 - Value select top bit clear sends the real conversion result.
// R09 - Selects 100/101/110/111 send zeros, ones, 0101 pattern, 0011 pattern.
// R10 - Reserved control bits, including 31-16, are read-only and read zero.
// R11 - Writable fields reset to zero; parity enable cleared by power-on only.
// R12 - Frame is data word, appended fields in fixed order, parity bits last.
`timescale 1ns/1ps
module aofc_output_frame_control
  import aofc_pkg::*;
#(
  parameter int DATA_W     = AOFC_DATA_W,
  parameter int FIFO_DEPTH = AOFC_FIFO_DEPTH
) (
  // Clock and resets
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   app_rst,
  // Register port
  input  wire logic [AOFC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // Conversion results
  input  wire logic                   conv_valid,
  input  wire logic [DATA_W-1:0]      conv_data,
  output logic                        conv_ready,
  // Live settings and alarm flags
  input  wire logic [3:0]             device_tag,
  input  wire logic [3:0]             range_code,
  input  wire logic                   supply_alarm_high,
  input  wire logic                   supply_alarm_low,
  input  wire logic                   input_alarm_high,
  input  wire logic                   input_alarm_low,
  // Serial frame output
  output logic                        serial_out_lanes,
  output logic                        serial_out_valid,
  output logic                        serial_out_last,
  input  wire logic                   host_ready
);

  // Longest frame: data, tag, four alarm flags, range code, parity pair
  localparam int FW = DATA_W + 14;
  localparam int LW = $clog2(FW + 1);
  localparam int EW = FW + LW;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    logic        device_tag_append;
    logic [1:0]  supply_alarm_append_sel;
    logic [1:0]  input_alarm_append_sel;
    logic        range_code_append;
    logic        parity_append_enable;
    logic [2:0]  output_value_select;
  } aofc_ctl_t;

  typedef struct packed {
    aofc_ctl_t   ctl;
    logic        stage_valid;
    logic [FW-1:0] stage_word;
    logic [LW-1:0] stage_len;
    logic        conv_ready;
    logic        busy;
    logic [FW-1:0] shift;
    logic [LW-1:0] remain;
    logic        sdo;
    logic        sdo_valid;
    logic        sdo_last;
    logic [31:0] rdata;
  } aofc_st_t;

  aofc_st_t      st_q;
  aofc_st_t      st_d;

  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [EW-1:0] fifo_out_data;
  logic [CW-1:0] fifo_level;

  // Places k bits of v, MSB first, right after the len bits already held
  function automatic logic [FW-1:0] add_bits(
    input logic [FW-1:0] acc,
    input logic [LW-1:0] len,
    input logic [3:0]    v,
    input logic [2:0]    k
  );
    logic [FW-1:0] r;
    int            pos;
    r = acc;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(k)) begin
        pos = FW - 1 - int'(len) - i;
        r[pos] = v[int'(k) - 1 - i];
      end
    end
    add_bits = r;
  endfunction : add_bits

  // Data word by value select
  function automatic logic [DATA_W-1:0] pick_value(
    input logic [2:0]        sel,
    input logic [DATA_W-1:0] raw
  );
    logic [DATA_W-1:0] v;
    v = raw;
    if (sel[2]) begin
      case (sel)
        AOFC_VAL_ZERO: v = DATA_W'(AOFC_PAT_ZERO);
        AOFC_VAL_ONE:  v = DATA_W'(AOFC_PAT_ONE);
        AOFC_VAL_ALT:  v = DATA_W'(AOFC_PAT_ALT);
        default:       v = DATA_W'(AOFC_PAT_PAIR);
      endcase
    end
    pick_value = v;
  endfunction : pick_value

  // Alarm pair by select code: 01 high only, 10 low only, 11 high then low
  function automatic logic [2:0] alarm_len(input logic [1:0] sel);
    logic [2:0] n;
    case (sel)
      2'h0:    n = 3'h0;
      2'h3:    n = 3'h2;
      default: n = 3'h1;
    endcase
    alarm_len = n;
  endfunction : alarm_len

  function automatic logic [3:0] alarm_bits(
    input logic [1:0] sel,
    input logic       hi,
    input logic       lo
  );
    logic [3:0] b;
    b = 4'h0;
    case (sel)
      2'h1:    b = {3'h0, hi};
      2'h2:    b = {3'h0, lo};
      2'h3:    b = {2'h0, hi, lo};
      default: b = 4'h0;
    endcase
    alarm_bits = b;
  endfunction : alarm_bits

  // Frame builder
  logic [DATA_W-1:0] value_word;
  logic [FW-1:0]     frame_word;
  logic [LW-1:0]     frame_len;
  logic              data_parity;
  logic              frame_parity;

  always_comb begin
    value_word  = pick_value(st_q.ctl.output_value_select, conv_data); // see R08 see R09
    frame_word  = '0;
    frame_word[FW-1 -: DATA_W] = value_word; // see R12
    frame_len   = LW'(DATA_W);
    // Live flags and codes ride with the sample, not with the later send
    if (st_q.ctl.device_tag_append) begin
      frame_word = add_bits(frame_word, frame_len, device_tag, 3'h4); // see R01
      frame_len  = LW'(frame_len + 4'h4);
    end

    // Supply flags, high before low
    if (st_q.ctl.supply_alarm_append_sel != 2'h0) begin
      frame_word = add_bits(frame_word, frame_len,
                            alarm_bits(st_q.ctl.supply_alarm_append_sel,
                                       supply_alarm_high, supply_alarm_low),
                            alarm_len(st_q.ctl.supply_alarm_append_sel)); // see R02
      frame_len  = LW'(frame_len + alarm_len(st_q.ctl.supply_alarm_append_sel));
    end

    // Input flags, high before low
    if (st_q.ctl.input_alarm_append_sel != 2'h0) begin
      frame_word = add_bits(frame_word, frame_len,
                            alarm_bits(st_q.ctl.input_alarm_append_sel,
                                       input_alarm_high, input_alarm_low),
                            alarm_len(st_q.ctl.input_alarm_append_sel)); // see R03
      frame_len  = LW'(frame_len + alarm_len(st_q.ctl.input_alarm_append_sel));
    end

    if (st_q.ctl.range_code_append) begin
      frame_word = add_bits(frame_word, frame_len, range_code, 3'h4); // see R04
      frame_len  = LW'(frame_len + 4'h4);
    end

    // Unused tail bits are zero, so the whole-word xor covers only the frame
    data_parity  = ^value_word;  // see R06
    frame_parity = ^frame_word;  // see R07
    // Parity pair closes the frame
    if (st_q.ctl.parity_append_enable) begin
      frame_word = add_bits(frame_word, frame_len,
                            {2'h0, data_parity, frame_parity}, 3'h2); // see R05 see R12
      frame_len  = LW'(frame_len + 2'h2);
    end
  end

  // Frames are queued so a slow host stalls conversions, not drops them
  aofc_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (st_q.stage_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({st_q.stage_word, st_q.stage_len}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  assign fifo_out_ready = !st_q.busy;

  // Control register read view; reserved positions stay zero
  function automatic logic [31:0] ctl_view(input aofc_ctl_t c);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[AOFC_TAG_BIT]             = c.device_tag_append;
    r[AOFC_SUP_LSB +: 2]        = c.supply_alarm_append_sel;
    r[AOFC_INP_LSB +: 2]        = c.input_alarm_append_sel;
    r[AOFC_RNG_BIT]             = c.range_code_append;
    r[AOFC_PAR_BIT]             = c.parity_append_enable;
    r[AOFC_VAL_LSB +: 3]        = c.output_value_select;
    ctl_view = r;
  endfunction : ctl_view

  // Status read view: stage held, sender busy, FIFO level
  function automatic logic [31:0] status_view(
    input logic          stage,
    input logic          busy,
    input logic [CW-1:0] level
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    r[AOFC_ST_STAGE]         = stage;
    r[AOFC_ST_BUSY]          = busy;
    r[AOFC_ST_LVL_LSB +: CW] = level;
    status_view = r;
  endfunction : status_view

  // Written word to fields; reserved positions are simply not stored
  function automatic aofc_ctl_t ctl_from_word(input logic [31:0] w);
    aofc_ctl_t c;
    c.device_tag_append       = w[AOFC_TAG_BIT];
    c.supply_alarm_append_sel = w[AOFC_SUP_LSB +: 2];
    c.input_alarm_append_sel  = w[AOFC_INP_LSB +: 2];
    c.range_code_append       = w[AOFC_RNG_BIT];
    c.parity_append_enable    = w[AOFC_PAR_BIT];
    c.output_value_select     = w[AOFC_VAL_LSB +: 3];
    ctl_from_word = c;
  endfunction : ctl_from_word

  // Application reset clears all but parity enable, which only power-on clears
  function automatic aofc_ctl_t ctl_app_clear(input aofc_ctl_t c);
    aofc_ctl_t r;
    r                         = c;
    r.device_tag_append       = AOFC_TAG_RST;
    r.supply_alarm_append_sel = AOFC_SUP_RST;
    r.input_alarm_append_sel  = AOFC_INP_RST;
    r.range_code_append       = AOFC_RNG_RST;
    r.output_value_select     = AOFC_VAL_RST;
    ctl_app_clear = r;
  endfunction : ctl_app_clear

  always_comb begin
    st_d = st_q;

    // Register writes; application reset wins over a same-cycle write
    if (reg_wr && (reg_addr == AOFC_CTL_ADDR)) begin
      st_d.ctl = ctl_from_word(reg_wdata);
    end
    if (app_rst) begin
      st_d.ctl = ctl_app_clear(st_d.ctl); // see R11
    end

    // Register reads, data valid in the following cycle only
    st_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == AOFC_CTL_ADDR) begin
        st_d.rdata = ctl_view(st_q.ctl); // see R10
      end else if (reg_addr == AOFC_STAT_ADDR) begin
        st_d.rdata = status_view(st_q.stage_valid, st_q.busy, fifo_level);
      end
    end

    // Stage: one built frame waiting for FIFO space
    if (st_q.stage_valid && fifo_in_ready) begin
      st_d.stage_valid = 1'b0;
    end
    if (conv_valid && st_q.conv_ready) begin
      st_d.stage_valid = 1'b1;
      st_d.stage_word  = frame_word;
      st_d.stage_len   = frame_len;
    end
    // Registered ready costs one bubble after every take but keeps the port flop-driven
    st_d.conv_ready = !st_d.stage_valid;

    // Serial sender, MSB first, one bit per accepted cycle
    // Length travels with the frame, so a control write never reshapes a queued one
    st_d.sdo_valid = 1'b0;
    st_d.sdo_last  = 1'b0;
    if (!st_q.busy) begin
      if (fifo_out_valid) begin
        st_d.busy   = 1'b1;
        st_d.shift  = fifo_out_data[EW-1 -: FW];
        st_d.remain = fifo_out_data[LW-1:0];
      end
    end else if (host_ready) begin
      st_d.sdo       = st_q.shift[FW-1]; // see R12
      st_d.sdo_valid = 1'b1;
      st_d.sdo_last  = (st_q.remain == LW'(1));
      st_d.shift     = {st_q.shift[FW-2:0], 1'b0};
      st_d.remain    = LW'(st_q.remain - 1'b1);
      st_d.busy      = (st_q.remain != LW'(1));
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q                          <= '0;
      // Only power-on clears parity enable
      st_q.ctl.parity_append_enable <= AOFC_PAR_RST; // see R11
      st_q.conv_ready               <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata        = st_q.rdata;
  assign conv_ready       = st_q.conv_ready;
  assign serial_out_lanes = st_q.sdo;
  assign serial_out_valid = st_q.sdo_valid;
  assign serial_out_last  = st_q.sdo_last;

endmodule : aofc_output_frame_control

// ===== aofc_props.sv
// Port checker for the output frame control block
`timescale 1ns/1ps
module aofc_props
  import aofc_pkg::*;
#(
  parameter int DATA_W     = AOFC_DATA_W,
  parameter int FIFO_DEPTH = AOFC_FIFO_DEPTH
) (
  // Clock and resets
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   app_rst,
  // Register port
  input wire logic [AOFC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // Stream handshakes
  input wire logic                   conv_valid,
  input wire logic                   conv_ready,
  input wire logic                   serial_out_valid,
  input wire logic                   serial_out_last,
  input wire logic                   host_ready
);
  logic [4:0] bits_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Bits already sent in the current frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bits_q <= 5'h0;
    end else if (serial_out_valid) begin
      bits_q <= serial_out_last ? 5'h0 : bits_q + 5'h1;
    end
  end

  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_reserved_read_zero: assert property ($past(reg_rd) && $past(reg_addr) == AOFC_CTL_ADDR
    |-> (reg_rdata & 32'hFFFF_82F0) == 32'h0) else $error("reserved control bits not zero");
  a_write_read_back: assert property ((reg_wr && reg_addr == AOFC_CTL_ADDR && !app_rst)
    ##1 (reg_rd && !reg_wr && reg_addr == AOFC_CTL_ADDR && !app_rst)
    |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000_7D0F)) else $error("control read back wrong");
  a_app_keeps_parity: assert property (app_rst ##1 (reg_rd && !reg_wr && !app_rst
    && reg_addr == AOFC_CTL_ADDR) |=> (reg_rdata & 32'hFFFF_FFF7) == 32'h0)
    else $error("application reset left a field set");
  a_bit_needs_host: assert property (serial_out_valid |-> $past(host_ready))
    else $error("bit sent without host ready");
  a_last_frame_len: assert property (serial_out_last
    |-> serial_out_valid && bits_q >= 5'd15 && bits_q <= 5'd29) else $error("frame length off");
  a_gap_after_last: assert property (serial_out_last |=> !serial_out_valid)
    else $error("no load gap after frame");
  a_take_drops_ready: assert property (conv_valid && conv_ready |=> !conv_ready)
    else $error("ready stayed high after take");
endmodule : aofc_props

bind aofc_output_frame_control aofc_props #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk, .sys_rst, .app_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .conv_valid, .conv_ready, .serial_out_valid, .serial_out_last, .host_ready);

// ===== aofc_host_model.sv
// Host model that collects serial frames
`timescale 1ns/1ps
module aofc_host_model (
  // Clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // Serial frame in
  input wire logic         serial_out_lanes,
  input wire logic         serial_out_valid,
  input wire logic         serial_out_last,
  output logic             host_ready,
  // Pace
  input wire logic         hold,
  input wire logic         slow,
  // Collected frame
  output logic [31:0]      frame_q,
  output logic [5:0]       len_q,
  output logic             done_q
);
  logic [31:0] acc_q;
  logic [5:0]  cnt_q;
  logic        tick_q;

  // Slow pace stalls every other cycle to stress the sender
  assign host_ready = !hold && !(slow && tick_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q   <= 32'h0;
      cnt_q   <= 6'h0;
      tick_q  <= 1'b0;
      frame_q <= 32'h0;
      len_q   <= 6'h0;
      done_q  <= 1'b0;
    end else begin
      tick_q <= !tick_q;
      done_q <= 1'b0;
      if (serial_out_valid) begin
        acc_q <= serial_out_last ? 32'h0 : {acc_q[30:0], serial_out_lanes};
        cnt_q <= serial_out_last ? 6'h0 : cnt_q + 6'h1;
        if (serial_out_last) begin
          frame_q <= {acc_q[30:0], serial_out_lanes};
          len_q   <= cnt_q + 6'h1;
          done_q  <= 1'b1;
        end
      end
    end
  end
endmodule : aofc_host_model

// ===== test_adc_output_frame_control.sv
// Testbench for the output frame control block
`timescale 1ns/1ps
module test_adc_output_frame_control;
  import aofc_pkg::*;
  typedef struct {logic [15:0] c; logic [15:0] d; logic [3:0] t; logic [3:0] r;
                  logic [3:0] al; int n;} aofc_row_t;
  logic        clk, sys_rst, app_rst, reg_wr, reg_rd, conv_valid, conv_ready, hold, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, f, frame_q;
  logic [15:0] conv_data;
  logic [3:0]  device_tag, range_code;
  logic        supply_alarm_high, supply_alarm_low, input_alarm_high, input_alarm_low;
  logic        serial_out_lanes, serial_out_valid, serial_out_last, host_ready, done_q;
  logic [5:0]  len_q;
  int          errors, tests_run, n, n_acc;
  bit          ok;
  aofc_row_t   rows [13] = '{
    '{16'h0000, 16'hA5C3, 4'h0, 4'h0, 4'h0, 16},
    '{16'h0003, 16'h1234, 4'h0, 4'h0, 4'h0, 16},
    '{16'h0004, 16'hFFFF, 4'h0, 4'h0, 4'h0, 16},
    '{16'h0005, 16'h0000, 4'h0, 4'h0, 4'h0, 16},
    '{16'h0006, 16'h0F0F, 4'h0, 4'h0, 4'h0, 16},
    '{16'h0007, 16'h0F0F, 4'h0, 4'h0, 4'h0, 16},
    '{16'h4000, 16'h8001, 4'h9, 4'h0, 4'h0, 20},
    '{16'h1000, 16'h0001, 4'h0, 4'h0, 4'h8, 17},
    '{16'h2400, 16'h0002, 4'h0, 4'h0, 4'h6, 18},
    '{16'h3C00, 16'h0003, 4'hF, 4'h0, 4'hD, 20},
    '{16'h0900, 16'h0004, 4'h0, 4'hA, 4'h1, 21},
    '{16'h7D08, 16'hBEEF, 4'h5, 4'h3, 4'hA, 30},
    '{16'h000E, 16'h0000, 4'h0, 4'h0, 4'h0, 18}};

  aofc_output_frame_control uut (.clk, .sys_rst, .app_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .conv_valid, .conv_data, .conv_ready, .device_tag, .range_code,
    .supply_alarm_high, .supply_alarm_low, .input_alarm_high, .input_alarm_low,
    .serial_out_lanes, .serial_out_valid, .serial_out_last, .host_ready);
  aofc_host_model u_host (.clk, .sys_rst, .serial_out_lanes, .serial_out_valid,
    .serial_out_last, .host_ready, .hold, .slow, .frame_q, .len_q, .done_q);

  always #4 clk = ~clk;

  // Expected frame built from the control word and live inputs
  function automatic void mk(input aofc_row_t x, output logic [31:0] fr, output int len);
    logic [15:0] w;
    logic        p;
    w = !x.c[2] ? x.d : x.c[1:0] == 2'h0 ? AOFC_PAT_ZERO : x.c[1:0] == 2'h1 ? AOFC_PAT_ONE
      : x.c[1:0] == 2'h2 ? AOFC_PAT_ALT : AOFC_PAT_PAIR;
    fr = {16'h0, w};
    len = 16;
    if (x.c[14]) begin fr = {fr[27:0], x.t}; len += 4; end
    if (x.c[12]) begin fr = {fr[30:0], x.al[3]}; len += 1; end
    if (x.c[13]) begin fr = {fr[30:0], x.al[2]}; len += 1; end
    if (x.c[10]) begin fr = {fr[30:0], x.al[1]}; len += 1; end
    if (x.c[11]) begin fr = {fr[30:0], x.al[0]}; len += 1; end
    if (x.c[8]) begin fr = {fr[27:0], x.r}; len += 4; end
    p = ^fr;
    if (x.c[3]) begin fr = {fr[29:0], ^w, p}; len += 2; end
  endfunction : mk

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
  endtask : chk_reg

  task automatic chk_frame(input logic [31:0] e, input int len);
    tests_run++;
    if (frame_q !== e || len_q !== len[5:0]) begin
      errors++;
      $display("[FAIL] frame expected %h/%0d seen %h/%0d", e, len, frame_q, len_q);
    end
  endtask : chk_frame

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  // Holds the sample until the edge that takes it; the caller drops valid
  task automatic send(input logic [15:0] d, output bit taken);
    conv_data <= d; conv_valid <= 1'b1; taken = 0;
    repeat (40) begin @(negedge clk); if (conv_ready) begin taken = 1; break; end end
    @(posedge clk);
  endtask : send

  task automatic get();
    repeat (300) begin @(posedge clk); if (done_q) break; end
  endtask : get

  task automatic close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    errors++;
    close_out();
  end

  initial begin
    {clk, app_rst, reg_wr, reg_rd, conv_valid, hold, slow} = '0;
    {reg_addr, reg_wdata, conv_data, device_tag, range_code} = '0;
    {supply_alarm_high, supply_alarm_low, input_alarm_high, input_alarm_low} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(AOFC_CTL_ADDR, v); chk_reg("ctl reset", 32'h0, v);
    foreach (rows[i]) begin
      wr(AOFC_CTL_ADDR, {16'h0, rows[i].c});
      device_tag <= rows[i].t; range_code <= rows[i].r; slow <= i[0];
      {supply_alarm_high, supply_alarm_low, input_alarm_high, input_alarm_low} <= rows[i].al;
      send(rows[i].d, ok); conv_valid <= 1'b0; get(); mk(rows[i], f, n);
      chk_frame(f, rows[i].n);
      chk_reg("frame length", rows[i].n, n);
    end
    // Reserved bits, unmapped place, then the two resets
    wr(AOFC_CTL_ADDR, 32'hFFFF_FFFF);
    rd(AOFC_CTL_ADDR, v); chk_reg("ctl reserved", 32'h0000_7D0F, v);
    rd(8'h20, v); chk_reg("unmapped", 32'h0, v);
    app_rst <= 1'b1;
    @(posedge clk);
    app_rst <= 1'b0;
    rd(AOFC_CTL_ADDR, v); chk_reg("ctl app reset", 32'h0000_0008, v);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(AOFC_CTL_ADDR, v); chk_reg("ctl power reset", 32'h0, v);
    // Host stalls until the buffer refuses, then drains everything in order
    hold <= 1'b1; slow <= 1'b1; n_acc = 0;
    for (int k = 0; k < 14; k++) begin
      send(16'h0100 + k[15:0], ok);
      if (!ok) break;
      n_acc++;
    end
    chk_reg("fill refused", 32'h1, {31'h0, n_acc >= AOFC_FIFO_DEPTH && n_acc < 14});
    rd(AOFC_STAT_ADDR, v); chk_reg("status full", 32'h0000_0083, v);
    hold <= 1'b0;
    // First frame ends before the refused sample can be taken
    get(); chk_frame(32'h0000_0100, 16);
    repeat (100) begin @(negedge clk); if (conv_ready) break; end
    @(posedge clk);
    conv_valid <= 1'b0;
    for (int k = 1; k <= n_acc; k++) begin
      get(); chk_frame({16'h0, 16'h0100 + k[15:0]}, 16);
    end
    close_out();
  end
endmodule : test_adc_output_frame_control
